// [shared/csr_pkg.sv]
// Summary of operation
// - Bank bits pick one of four register banks
// - Bit zero tracks even parity of accumulator
// - Bit five is a free user flag
// - Bit one is a second free flag
// - Stack pointer resets to 0x07
// - Stack pointer increments before each push
// - Data pointer is sixteen bits, two bytes
// - Data pointer loads whole or by halves
// - Data pointer addresses tables and external data
// - Fetch counter resets to 0x0000
// - Fetch counter advances per opcode or operand; an opcode and operand fetch in one cycle step it once
// - Fetch counter has no register address
// - Accept updates from every core instruction; PSW_WE skips parity, PUSH with POP holds the pointer
package csr_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_STACK  = 8'h04;
  localparam logic [7:0] OFF_DLOW   = 8'h08;
  localparam logic [7:0] OFF_DHIGH  = 8'h0c;

  // Status word field positions
  localparam int CARRY_BIT  = 7;
  localparam int HALF_BIT   = 6;
  localparam int USER0_BIT  = 5;
  localparam int BANK_HI    = 4;
  localparam int BANK_LO    = 3;
  localparam int WRAP_BIT   = 2;
  localparam int USER1_BIT  = 1;
  localparam int PARITY_BIT = 0;

  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [7:0]  STACK_RST  = 8'h07;
  localparam logic [15:0] DATA_ADDRESS_PAIR_RST   = 16'h0000;
  localparam logic [15:0] FETCH_RST  = 16'h0000;

  // Bank geometry and bus codes
  localparam int         BANK_SHIFT = 3;
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;

endpackage : csr_pkg

// [rtl/csr_flag_calc.sv]
`timescale 1ns/1ns
module csr_flag_calc (
  // Operands
  input  logic [7:0] op_a,
  input  logic [7:0] op_b,
  input  logic       subtract,
  input  logic       carry_in,
  input  logic [7:0] acc,
  // Flags
  output logic       carry_out,
  output logic       half_out,
  output logic       wrap_out,
  output logic       parity_out
);

  logic [7:0] b_eff;
  logic       c_eff;
  logic [8:0] sum;
  logic [4:0] nib;

  // Subtract as add of the complement; borrow is the inverted carry
  assign b_eff = subtract ? ~op_b : op_b;
  assign c_eff = subtract ? ~carry_in : carry_in;
  assign sum   = {1'b0, op_a} + {1'b0, b_eff} + {8'h00, c_eff};
  assign nib   = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};

  assign carry_out  = sum[8] ^ subtract;
  assign half_out   = nib[4] ^ subtract;
  assign wrap_out   = (op_a[7] == b_eff[7]) && (sum[7] != op_a[7]);
  assign parity_out = ^acc;

endmodule : csr_flag_calc

// [rtl/csr_regs.sv]
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module csr_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  logic              CLK,
  input  logic              RST_N,
  // AHB-Lite slave
  input  logic              HSEL,
  input  logic [ADDR_W-1:0] HADDR,
  input  logic [1:0]        HTRANS,
  input  logic              HWRITE,
  input  logic [2:0]        HSIZE,
  input  logic [31:0]       HWDATA,
  input  logic              HREADY,
  output logic [31:0]       HRDATA,
  output logic              HREADYOUT,
  output logic              HRESP,
  // Accumulator from the core
  input  logic [7:0]        ACC,
  // Arithmetic flag update
  input  logic              ARITH_VALID,
  input  logic              ARITH_SUB,
  input  logic              ARITH_USE_CARRY,
  input  logic [7:0]        ARITH_A,
  input  logic [7:0]        ARITH_B,
  // Direct flag and status writes
  input  logic              CARRY_WE,
  input  logic              CARRY_VAL,
  input  logic              PSW_WE,
  input  logic [7:0]        PSW_WDATA,
  // Stack pointer control
  input  logic              PUSH,
  input  logic              POP,
  input  logic              SP_WE,
  input  logic [7:0]        SP_WDATA,
  // Data pointer control
  input  logic              DATA_ADDRESS_PAIR_LD16,
  input  logic [15:0]       DATA_ADDRESS_PAIR_DATA,
  input  logic              DPL_WE,
  input  logic              DPH_WE,
  input  logic [7:0]        DPB_DATA,
  input  logic              DATA_ADDRESS_PAIR_INC,
  // Fetch counter control
  input  logic              FETCH_OP,
  input  logic              FETCH_OPND,
  input  logic              PC_LOAD,
  input  logic [15:0]       PC_TARGET,
  // State towards the core
  output logic [7:0]        STATUS_WORD,
  output logic [7:0]        STACK_TOP,
  output logic [7:0]        BANK_BASE,
  output logic [15:0]       XDATA_ADDR,
  output logic [15:0]       CODE_TABLE_ADDR,
  output logic [15:0]       FETCH_ADDR
);

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  logic [7:0]  psw_q;
  logic [7:0]  psw_d;
  logic [7:0]  sp_q;
  logic [7:0]  sp_d;
  logic [15:0] data_address_pair_q;
  logic [15:0] data_address_pair_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [15:0] tab_q;
  logic [31:0] rdata_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;

  // Bus decode
  wire         addr_ok  = HSEL && HREADY && (HTRANS[1] == 1'b1);
  wire         wr_take  = addr_ok && HWRITE;
  wire         rd_take  = addr_ok && !HWRITE;
  wire         hit_stat = HADDR == ADDR_W'(csr_pkg::OFF_STATUS);
  wire         hit_stk  = HADDR == ADDR_W'(csr_pkg::OFF_STACK);
  wire         hit_dlo  = HADDR == ADDR_W'(csr_pkg::OFF_DLOW);
  wire         hit_dhi  = HADDR == ADDR_W'(csr_pkg::OFF_DHIGH);
  // Unmapped reads return zero; the fetch counter has no slot
  wire [7:0]   rd_byte  = hit_stat ? psw_q :
                          hit_stk  ? sp_q :
                          hit_dlo  ? data_address_pair_q[7:0] :
                          hit_dhi  ? data_address_pair_q[15:8] : 8'h00;
  wire         bw_stat  = wr_pend_q && (wr_addr_q == csr_pkg::OFF_STATUS);
  wire         bw_stk   = wr_pend_q && (wr_addr_q == csr_pkg::OFF_STACK);
  wire         bw_dlo   = wr_pend_q && (wr_addr_q == csr_pkg::OFF_DLOW);
  wire         bw_dhi   = wr_pend_q && (wr_addr_q == csr_pkg::OFF_DHIGH);
  wire [7:0]   wbyte    = HWDATA[7:0];

  // Flag arithmetic
  logic        ar_carry;
  logic        ar_half;
  logic        ar_wrap;
  logic        acc_par;
  wire         ar_cin   = ARITH_USE_CARRY && psw_q[csr_pkg::CARRY_BIT];

  csr_flag_calc u_flags (
    .op_a       (ARITH_A),
    .op_b       (ARITH_B),
    .subtract   (ARITH_SUB),
    .carry_in   (ar_cin),
    .acc        (ACC),
    .carry_out  (ar_carry),
    .half_out   (ar_half),
    .wrap_out   (ar_wrap),
    .parity_out (acc_par)
  );

  // Core instruction writes win over a bus write in the same cycle
  wire [7:0]   psw_sw   = bw_stat ? wbyte : psw_q;
  wire [7:0]   psw_in   = PSW_WE ? PSW_WDATA : psw_sw;

  always_comb begin
    psw_d = psw_in;
    if (ARITH_VALID) begin
      psw_d[csr_pkg::CARRY_BIT] = ar_carry;
      psw_d[csr_pkg::HALF_BIT]  = ar_half;
      psw_d[csr_pkg::WRAP_BIT]  = ar_wrap;
    end
    if (CARRY_WE) begin
      psw_d[csr_pkg::CARRY_BIT] = CARRY_VAL;
    end
    // Parity is never writable; it lags the accumulator by one cycle
    psw_d[csr_pkg::PARITY_BIT] = acc_par;
  end

  // Stack pointer: pre-increment on push, post-decrement on pop
  assign sp_d = SP_WE ? SP_WDATA :
                (PUSH && !POP) ? sp_q + 8'h01 :
                (POP && !PUSH) ? sp_q - 8'h01 :
                bw_stk ? wbyte : sp_q;

  // Data pointer, loaded whole or by byte
  wire [7:0]   dpl_n    = DPL_WE ? DPB_DATA : bw_dlo ? wbyte : data_address_pair_q[7:0];
  wire [7:0]   dph_n    = DPH_WE ? DPB_DATA : bw_dhi ? wbyte : data_address_pair_q[15:8];
  assign data_address_pair_d = DATA_ADDRESS_PAIR_LD16 ? DATA_ADDRESS_PAIR_DATA :
                  DATA_ADDRESS_PAIR_INC ? data_address_pair_q + 16'h0001 :
                  {dph_n, dpl_n};

  // Opcode and operand fetch in one cycle still count as one step
  assign pc_d = PC_LOAD ? PC_TARGET :
                (FETCH_OP || FETCH_OPND) ? pc_q + 16'h0001 : pc_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      psw_q  <= csr_pkg::STATUS_RST;
      sp_q   <= csr_pkg::STACK_RST;
      data_address_pair_q <= csr_pkg::DATA_ADDRESS_PAIR_RST;
      pc_q   <= csr_pkg::FETCH_RST;
    end else begin
      psw_q  <= psw_d;
      sp_q   <= sp_d;
      data_address_pair_q <= data_address_pair_d;
      pc_q   <= pc_d;
    end
  end

  // Table address is registered, so it trails the pointer by a cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tab_q <= 16'h0000;
    end else begin
      tab_q <= data_address_pair_q + {8'h00, ACC};
    end
  end

  // Bus slave: zero wait states, writes land at the end of the data phase
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_addr_q <= HADDR[7:0];
      end
      if (rd_take) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign HRDATA          = rdata_q;
  assign HREADYOUT       = 1'b1;
  assign HRESP           = csr_pkg::RESP_OKAY[0];
  assign STATUS_WORD     = psw_q;
  assign STACK_TOP       = sp_q;
  assign BANK_BASE       = {3'h0, psw_q[csr_pkg::BANK_HI:csr_pkg::BANK_LO], 3'h0};
  assign XDATA_ADDR      = data_address_pair_q;
  assign CODE_TABLE_ADDR = tab_q;
  assign FETCH_ADDR      = pc_q;

  // Checks

  sp_reset_a: assert property (
    @(posedge CLK) !RST_N |=> (sp_q == 8'h07))
    else $error("stack pointer not 0x07 after reset");

  pc_reset_a: assert property (
    @(posedge CLK) !RST_N |=> (pc_q == 16'h0000))
    else $error("fetch counter not zero after reset");

  push_inc_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (PUSH && !POP && !SP_WE) |=> (sp_q == $past(sp_q) + 8'h01))
    else $error("push did not pre-increment stack pointer");

  parity_track_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    $past(RST_N) |-> (psw_q[csr_pkg::PARITY_BIT] == ^$past(ACC)))
    else $error("parity bit does not match accumulator");

  user_flags_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (bw_stat && !PSW_WE) |=> (psw_q[5] == $past(HWDATA[5]))
                             && (psw_q[1] == $past(HWDATA[1])))
    else $error("user flag write lost");

  bank_sel_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (bw_stat && !PSW_WE) |=> (BANK_BASE == {3'h0, $past(HWDATA[4:3]), 3'h0})
                             && (BANK_BASE <= 8'h18))
    else $error("bank base does not follow bank bits");

  carry_upd_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (ARITH_VALID && !CARRY_WE) |=> (psw_q[7] == $past(ar_carry))
                                   && (psw_q[2] == $past(ar_wrap)))
    else $error("arithmetic flags not updated");

  data_address_pair_load_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    DATA_ADDRESS_PAIR_LD16 |=> (XDATA_ADDR == $past(DATA_ADDRESS_PAIR_DATA)))
    else $error("sixteen-bit pointer load lost");

  data_address_pair_half_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (DPL_WE && !DPH_WE && !DATA_ADDRESS_PAIR_LD16 && !DATA_ADDRESS_PAIR_INC && !bw_dhi)
      |=> (data_address_pair_q == {$past(data_address_pair_q[15:8]), $past(DPB_DATA)}))
    else $error("low byte load disturbed the pointer");

  table_addr_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ##1 (CODE_TABLE_ADDR == $past(data_address_pair_q) + {8'h00, $past(ACC)}))
    else $error("table address not pointer plus accumulator");

  pc_step_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ((FETCH_OP || FETCH_OPND) && !PC_LOAD) |=> (pc_q == $past(pc_q) + 16'h0001))
    else $error("fetch counter did not advance");

  pc_hidden_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (wr_pend_q && !FETCH_OP && !FETCH_OPND && !PC_LOAD) |=> $stable(pc_q))
    else $error("bus write reached the fetch counter");

  bus_okay_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    rd_take |=> HREADYOUT && !HRESP && (HRDATA[31:8] == 24'h00_0000))
    else $error("bus answer not a zero-wait OKAY");

  sp_write_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    SP_WE |=> (sp_q == $past(SP_WDATA)))
    else $error("direct stack pointer write lost");

  pop_dec_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (POP && !PUSH && !SP_WE) |=> (sp_q == $past(sp_q) - 8'h01))
    else $error("pop did not decrement stack pointer");

  carry_write_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CARRY_WE |=> (psw_q[7] == $past(CARRY_VAL)))
    else $error("direct carry write lost");

  half_upd_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ARITH_VALID |=> (psw_q[6] == $past(ar_half)))
    else $error("half-carry flag not updated");

  psw_write_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (PSW_WE && !ARITH_VALID && !CARRY_WE) |=> (psw_q[7:1] == $past(PSW_WDATA[7:1])))
    else $error("status word write lost");

  pc_load_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    PC_LOAD |=> (pc_q == $past(PC_TARGET)))
    else $error("jump load of fetch counter lost");

  data_address_pair_inc_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (DATA_ADDRESS_PAIR_INC && !DATA_ADDRESS_PAIR_LD16) |=> (data_address_pair_q == $past(data_address_pair_q) + 16'h0001))
    else $error("pointer increment lost");

  data_address_pair_high_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (DPH_WE && !DATA_ADDRESS_PAIR_LD16 && !DATA_ADDRESS_PAIR_INC) |=> (data_address_pair_q[15:8] == $past(DPB_DATA)))
    else $error("high byte load lost");

endmodule : csr_regs

// [tb/csr_regs_tb.sv]
`timescale 1ns/1ns
module csr_regs_tb;
  logic        CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  logic [7:0]  HADDR, ACC, ARITH_A, ARITH_B, PSW_WDATA, SP_WDATA, DPB_DATA;
  logic [7:0]  STATUS_WORD, STACK_TOP, BANK_BASE, r;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA;
  logic [15:0] DATA_ADDRESS_PAIR_DATA, PC_TARGET, XDATA_ADDR, CODE_TABLE_ADDR, FETCH_ADDR;
  logic        ARITH_VALID, ARITH_SUB, ARITH_USE_CARRY, CARRY_WE, CARRY_VAL, PSW_WE;
  logic        PUSH, POP, SP_WE, DATA_ADDRESS_PAIR_LD16, DPL_WE, DPH_WE, DATA_ADDRESS_PAIR_INC;
  logic        FETCH_OP, FETCH_OPND, PC_LOAD;
  int          bad_count, cmp_count;

  // Single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  csr_regs u_dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ACC(ACC), .ARITH_VALID(ARITH_VALID),
    .ARITH_SUB(ARITH_SUB), .ARITH_USE_CARRY(ARITH_USE_CARRY), .ARITH_A(ARITH_A),
    .ARITH_B(ARITH_B), .CARRY_WE(CARRY_WE), .CARRY_VAL(CARRY_VAL), .PSW_WE(PSW_WE),
    .PSW_WDATA(PSW_WDATA), .PUSH(PUSH), .POP(POP), .SP_WE(SP_WE), .SP_WDATA(SP_WDATA),
    .DATA_ADDRESS_PAIR_LD16(DATA_ADDRESS_PAIR_LD16), .DATA_ADDRESS_PAIR_DATA(DATA_ADDRESS_PAIR_DATA), .DPL_WE(DPL_WE), .DPH_WE(DPH_WE),
    .DPB_DATA(DPB_DATA), .DATA_ADDRESS_PAIR_INC(DATA_ADDRESS_PAIR_INC), .FETCH_OP(FETCH_OP), .FETCH_OPND(FETCH_OPND),
    .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET), .STATUS_WORD(STATUS_WORD),
    .STACK_TOP(STACK_TOP), .BANK_BASE(BANK_BASE), .XDATA_ADDR(XDATA_ADDR),
    .CODE_TABLE_ADDR(CODE_TABLE_ADDR), .FETCH_ADDR(FETCH_ADDR));

  always #20 CLK = ~CLK;

  task cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp8

  task cmp16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp16

  // Master waits on ready at every phase; only the watchdog ends a hang
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    HTRANS <= 2'h2;
    HADDR  <= a;
    HWRITE <= w;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    HTRANS <= csr_pkg::TRANS_IDLE;
    HWDATA <= {24'h000000, d};
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    r = HRDATA[7:0];
    #1;
  endtask : bus

  task rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp8(r, e);
  endtask : rdchk

  task t_reset;
    cmp8(STATUS_WORD, 8'h00);
    cmp8(STACK_TOP, 8'h07);
    cmp16(FETCH_ADDR, 16'h0000);
    cmp16(XDATA_ADDR, 16'h0000);
    cmp8({7'h00, HRESP}, 8'h00);
    cmp8({7'h00, HREADYOUT}, 8'h01);
    $display("test reset done");
  endtask : t_reset

  task t_status;
    for (int b = 0; b < 4; b++) begin
      bus(1'b1, csr_pkg::OFF_STATUS, 8'(b << 3));
      cmp8(BANK_BASE, 8'(b * 8));
    end
    @(posedge CLK) ACC <= 8'h07;
    repeat (2) @(posedge CLK);
    #1 cmp8({7'h00, STATUS_WORD[0]}, 8'h01);
    @(posedge CLK) ACC <= 8'h03;
    bus(1'b1, csr_pkg::OFF_STATUS, 8'h21);
    rdchk(csr_pkg::OFF_STATUS, 8'h20);
    bus(1'b1, csr_pkg::OFF_STATUS, 8'h02);
    rdchk(csr_pkg::OFF_STATUS, 8'h02);
    bus(1'b1, csr_pkg::OFF_STATUS, 8'h00);
    rdchk(8'h10, 8'h00);
    bus(1'b1, 8'h10, 8'hff);
    cmp16(FETCH_ADDR, 16'h0000);
    $display("test status done");
  endtask : t_status

  task arith(input logic [7:0] a, input logic [7:0] b, input logic s, input logic [7:0] e);
    @(posedge CLK);
    ARITH_A     <= a;
    ARITH_B     <= b;
    ARITH_SUB   <= s;
    ARITH_VALID <= 1'b1;
    @(posedge CLK) ARITH_VALID <= 1'b0;
    #1 cmp8(STATUS_WORD & 8'hc4, e);
  endtask : arith

  task t_stack;
    @(posedge CLK) PUSH <= 1'b1;
    @(posedge CLK) PUSH <= 1'b0;
    #1 cmp8(STACK_TOP, 8'h08);
    bus(1'b1, csr_pkg::OFF_STACK, 8'h30);
    rdchk(csr_pkg::OFF_STACK, 8'h30);
    $display("test stack done");
  endtask : t_stack

  task t_data_address_pair;
    @(posedge CLK) begin DATA_ADDRESS_PAIR_LD16 <= 1'b1; DATA_ADDRESS_PAIR_DATA <= 16'h1234; ACC <= 8'h10; end
    @(posedge CLK) begin DATA_ADDRESS_PAIR_LD16 <= 1'b0; DPL_WE <= 1'b1; DPB_DATA <= 8'h56; end
    #1 cmp16(XDATA_ADDR, 16'h1234);
    @(posedge CLK) DPL_WE <= 1'b0;
    #1 cmp16(XDATA_ADDR, 16'h1256);
    bus(1'b1, csr_pkg::OFF_DHIGH, 8'hab);
    @(posedge CLK) DATA_ADDRESS_PAIR_INC <= 1'b1;
    @(posedge CLK) DATA_ADDRESS_PAIR_INC <= 1'b0;
    #1 cmp16(XDATA_ADDR, 16'hab57);
    rdchk(csr_pkg::OFF_DLOW, 8'h57);
    cmp16(CODE_TABLE_ADDR, 16'hab67);
    $display("test pointer done");
  endtask : t_data_address_pair

  task t_fetch;
    @(posedge CLK) FETCH_OP <= 1'b1;
    @(posedge CLK) FETCH_OPND <= 1'b1;
    @(posedge CLK) FETCH_OP <= 1'b0;
    @(posedge CLK) begin FETCH_OPND <= 1'b0; PC_LOAD <= 1'b1; PC_TARGET <= 16'h0100; end
    #1 cmp16(FETCH_ADDR, 16'h0003);
    @(posedge CLK) PC_LOAD <= 1'b0;
    #1 cmp16(FETCH_ADDR, 16'h0100);
    $display("test fetch done");
  endtask : t_fetch

  // Core-side writes and priorities, then a reset in mid-run
  task t_core;
    @(posedge CLK) begin PSW_WE <= 1'b1; PSW_WDATA <= 8'h18; end
    @(posedge CLK) begin PSW_WE <= 1'b0; CARRY_WE <= 1'b1; CARRY_VAL <= 1'b1; end
    #1 cmp8(STATUS_WORD, 8'h19);
    cmp8(BANK_BASE, 8'h18);
    @(posedge CLK) begin CARRY_WE <= 1'b0; ARITH_USE_CARRY <= 1'b1; end
    #1 cmp8(STATUS_WORD, 8'h99);
    arith(8'h0f, 8'h00, 1'b0, 8'h40);
    @(posedge CLK) begin ARITH_USE_CARRY <= 1'b0; SP_WE <= 1'b1; SP_WDATA <= 8'h40; PUSH <= 1'b1; end
    @(posedge CLK) begin SP_WE <= 1'b0; PUSH <= 1'b0; POP <= 1'b1; end
    #1 cmp8(STACK_TOP, 8'h40);
    @(posedge CLK) PUSH <= 1'b1;
    #1 cmp8(STACK_TOP, 8'h3f);
    @(posedge CLK) begin PUSH <= 1'b0; POP <= 1'b0; end
    #1 cmp8(STACK_TOP, 8'h3f);
    @(posedge CLK) RST_N <= 1'b0;
    @(posedge CLK) RST_N <= 1'b1;
    #1 t_reset();
    $display("test core done");
  endtask : t_core

  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    #(40 * 3000);
    bad_count++;
    final_report();
  end

  initial begin
    {CLK, RST_N, HSEL, HWRITE, ARITH_VALID, ARITH_SUB, ARITH_USE_CARRY} = '0;
    {CARRY_WE, CARRY_VAL, PSW_WE, PUSH, POP, SP_WE, DATA_ADDRESS_PAIR_LD16, DPL_WE, DPH_WE} = '0;
    {DATA_ADDRESS_PAIR_INC, FETCH_OP, FETCH_OPND, PC_LOAD, HTRANS, HSIZE, HWDATA, HADDR} = '0;
    {ACC, ARITH_A, ARITH_B, PSW_WDATA, SP_WDATA, DPB_DATA, DATA_ADDRESS_PAIR_DATA, PC_TARGET} = '0;
    HSIZE = 3'h2;
    HSEL  = 1'b1;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    #1 t_reset();
    t_status();
    arith(8'hff, 8'h01, 1'b0, 8'hc0);
    arith(8'h7f, 8'h01, 1'b0, 8'h44);
    arith(8'h00, 8'h01, 1'b1, 8'hc0);
    arith(8'h80, 8'h01, 1'b1, 8'h44);
    $display("test flags done");
    t_stack();
    t_data_address_pair();
    t_fetch();
    t_core();
    final_report();
  end
endmodule : csr_regs_tb
